/* File: hdl/mfc_pkg.sv */
/*
 Constants and types shared by the match/fail combination logic.
 Assumes a single 250 MHz system clock with a synchronous reset.
*/
package mfc_pkg;
   // System clock figures
   localparam int MFC_CLK_MHZ     = 250;
   localparam int MFC_CLK_NS      = 4;
   // Settling time after the reference PLL reports lock
   localparam int MFC_LOCK_NS     = 1000;
   localparam int MFC_LOCK_CYC    = (MFC_LOCK_NS * MFC_CLK_MHZ + 999) / 1000;
   localparam int MFC_LOCK_W      = 8;
   // Site and trigger bus sizes
   localparam int MFC_SITES       = 8;
   localparam int MFC_TRIG_LINES  = 8;
   localparam int MFC_TSEL_W      = 3;
   // Alignment delay line
   localparam int MFC_DLY_DEPTH   = 16;
   localparam int MFC_DLY_W       = 4;
   // Reset values
   localparam logic [7:0] MFC_FAIL_RST = 8'h00;
   localparam logic [7:0] MFC_CNT_RST  = 8'h00;

   // Burst sequence states
   typedef enum logic [1:0] {
      MFC_IDLE,
      MFC_ARMED,
      MFC_RUN
   } mfc_state_e;

   // Whole state of the core
   typedef struct packed {
      mfc_state_e             st;
      logic [MFC_LOCK_W-1:0]  lock_cnt;
      logic                   locked;
      logic                   trig_prev;
      logic                   comb_mode;
      logic                   go;
      logic [MFC_SITES-1:0]   fail_sticky;
      logic                   fail_out;
      logic                   match_out;
      logic                   cond_f;
      logic                   cond_m;
      logic                   cond_v;
   } mfc_core_s;

   // Whole state of the alignment delay line
   typedef struct packed {
      logic [MFC_DLY_DEPTH-1:0] line;
      logic                     out;
   } mfc_align_s;
endpackage

/* File: hdl/mfc_trig_if.sv */
/*
 Carrier between the core and its trigger alignment delay line.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface mfc_trig_if;
   import mfc_pkg::*;
   logic                 trig_in;    // Start event pulse
   logic [MFC_DLY_W-1:0] delay;      // Extra cycles of delay
   logic                 trig_out;   // Aligned start pulse

   modport core  (output trig_in, output delay, input trig_out);
   modport align (input trig_in, input delay, output trig_out);
endinterface

/* File: hdl/mfc_trig_align.sv */
/*
 Trigger alignment delay line: shifts the start event by a programmed
 number of cycles so synchronized instruments share one timing reference.
 Assumes the delay setting is held steady while a burst is armed.
*/
`timescale 1ns/10ps
module mfc_trig_align
   import mfc_pkg::*;
(
   input wire logic sys_clk,         // System clock
   input wire logic rst,             // Synchronous reset, high
   mfc_trig_if.align tif              // Trigger carrier
);
   mfc_align_s q_ff;
   mfc_align_s nxt_q;

   always_comb begin
      nxt_q      = q_ff;
      nxt_q.line = {q_ff.line[MFC_DLY_DEPTH-2:0], tif.trig_in};
      nxt_q.out  = nxt_q.line[tif.delay];
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign tif.trig_out = q_ff.out;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_DLY_ZERO: assert property (
      tif.trig_in && tif.delay == 4'h0 |=> tif.trig_out)
      else $error("Undelayed trigger not passed after one cycle");
   AST_DLY_THREE: assert property (
      tif.trig_in && tif.delay == 4'h3 |-> ##4 tif.trig_out)
      else $error("Trigger with delay three not seen after four cycles");
   COV_DLY: cover property (tif.trig_in && tif.delay != 4'h0);
endmodule

/* File: hdl/mfc_core.sv */
/*
 Match/fail combination core of one digital pattern instrument: timebase
 lock qualification, deterministic start trigger, per-vector matched and
 failed evaluation, and combination of results across instruments.
 Assumes a timing module on the backplane ORs every instrument's fail
 contribution and ANDs every match contribution, returning both with the
 same fixed latency to all instruments, flagged by bp_valid.
*/
// Behaviour
// - Master timebase must be locked to the 100 MHz backplane reference.
// - Start triggers come over the trigger bus, same cycle everywhere.
// - A programmed absolute delay shifts the local timing reference.
// - Sequencer evaluates matched and failed during a burst for branching.
// - Combined failed is true when any enabled site anywhere fails.
// - Per-site pass/fail shows only this instrument's own failing sites.
// - Combined matched needs every enabled site with match pins matching.
// - Combined mode: all branch alike, no local or per-site branching.
// - Without timing module, local evaluation and independent branching; if combine_enable is set, the core arms no burst.
`timescale 1ns/10ps
module mfc_core
   import mfc_pkg::*;
(
   input  wire logic                   sys_clk,        // System clock
   input  wire logic                   rst,            // Sync reset, high
   input  wire logic                   ref_locked,     // PLL on reference
   output logic                        master_timebase_clock_ok, // Locked
   input  wire logic                   sync_enable,    // Timing module up
   input  wire logic                   combine_enable, // Combine results
   input  wire logic [MFC_DLY_W-1:0]   abs_delay,      // Delay, cycles
   input  wire logic [MFC_TRIG_LINES-1:0] trig_bus,    // Backplane lines
   input  wire logic [MFC_TSEL_W-1:0]  trig_sel,       // Start line
   input  wire logic                   sw_start,       // Software start
   input  wire logic                   burst_arm,      // Arm a burst
   input  wire logic                   burst_done,     // Pattern ended
   input  wire logic [MFC_SITES-1:0]   site_enable,    // Sites bursting
   input  wire logic [MFC_SITES-1:0]   site_fail,      // Vector failed
   input  wire logic [MFC_SITES-1:0]   site_match,     // Match satisfied
   input  wire logic [MFC_SITES-1:0]   site_in_match,  // Has match pins
   input  wire logic                   cmp_valid,      // Compare strobe
   input  wire logic                   bp_valid,       // Combined ready
   input  wire logic                   bp_fail_in,     // Combined fail
   input  wire logic                   bp_match_in,    // Combined match
   output logic                        bp_fail_out,    // Our fail share
   output logic                        bp_match_out,   // Our match share
   output logic                        start_go,       // Burst starts
   output logic                        burst_active,   // Burst running
   output logic                        cond_valid,     // Decision pulse
   output logic                        cond_failed,    // Failed operand
   output logic                        cond_matched,   // Matched operand
   output logic [MFC_SITES-1:0]        site_pass_fail  // Own fails, sticky
);
   mfc_core_s  q_ff;
   mfc_core_s  nxt_q;
   mfc_trig_if tif ();
   logic       trig_line;
   logic       trig_edge;
   logic       local_fail;
   logic       local_match;
   logic       running;

   // Any enabled site failed
   function automatic logic mfc_any_fail(
      input logic [MFC_SITES-1:0] en,
      input logic [MFC_SITES-1:0] fail);
      return |(en & fail);
   endfunction

   // All enabled sites with match pins matched
   function automatic logic mfc_all_match(
      input logic [MFC_SITES-1:0] en,
      input logic [MFC_SITES-1:0] pins,
      input logic [MFC_SITES-1:0] match);
      return &(~(en & pins) | match);
   endfunction

   // Start event from the selected bus line or software
   assign trig_line   = trig_bus[trig_sel];
   assign trig_edge   = trig_line & ~q_ff.trig_prev;
   assign tif.trig_in = (q_ff.st == MFC_ARMED) & (trig_edge | sw_start);
   assign tif.delay   = abs_delay;

   mfc_trig_align u_align (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tif     (tif.align)
   );

   // Local evaluation of this vector
   assign running     = (q_ff.st == MFC_RUN);
   assign local_fail  = mfc_any_fail(site_enable, site_fail);
   assign local_match = mfc_all_match(site_enable, site_in_match,
                                      site_match);

   // Next state
   always_comb begin
      nxt_q           = q_ff;
      nxt_q.trig_prev = trig_line;
      nxt_q.go        = 1'b0;
      nxt_q.cond_v    = 1'b0;
      nxt_q.fail_out  = 1'b0;
      nxt_q.match_out = 1'b1;
      if (!ref_locked) begin
         nxt_q.lock_cnt = MFC_CNT_RST;
         nxt_q.locked   = 1'b0;
      end else if (q_ff.lock_cnt == MFC_LOCK_W'(MFC_LOCK_CYC - 1)) begin
         nxt_q.locked   = 1'b1;
      end else begin
         nxt_q.lock_cnt = q_ff.lock_cnt + 8'h01;
      end
      unique case (q_ff.st)
         MFC_IDLE: begin
            if (burst_arm && q_ff.locked &&
                (!combine_enable || sync_enable)) begin
               nxt_q.st          = MFC_ARMED;
               nxt_q.comb_mode   = combine_enable & sync_enable;
               nxt_q.fail_sticky = MFC_FAIL_RST;
            end
         end
         MFC_ARMED: begin
            if (tif.trig_out) begin
               nxt_q.st = MFC_RUN;
               nxt_q.go = 1'b1;
            end
         end
         MFC_RUN: begin
            if (burst_done || !q_ff.locked) begin
               nxt_q.st = MFC_IDLE;
            end
            if (cmp_valid) begin
               nxt_q.fail_sticky = q_ff.fail_sticky | (site_enable &
                                                        site_fail);
               nxt_q.fail_out    = local_fail;
               nxt_q.match_out   = local_match;
            end
            if (q_ff.comb_mode) begin
               if (bp_valid) begin
                  nxt_q.cond_f = bp_fail_in;
                  nxt_q.cond_m = bp_match_in;
                  nxt_q.cond_v = 1'b1;
               end
            end else if (cmp_valid) begin
               nxt_q.cond_f = local_fail;
               nxt_q.cond_m = local_match;
               nxt_q.cond_v = 1'b1;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_ff    <= '0;
         q_ff.st <= MFC_IDLE;
         q_ff.match_out <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Outputs from state
   assign master_timebase_clock_ok = q_ff.locked;
   assign bp_fail_out    = q_ff.fail_out;
   assign bp_match_out   = q_ff.match_out;
   assign start_go       = q_ff.go;
   assign burst_active   = running;
   assign cond_valid     = q_ff.cond_v;
   assign cond_failed    = q_ff.cond_f;
   assign cond_matched   = q_ff.cond_m;
   assign site_pass_fail = q_ff.fail_sticky;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_LOCK_DROP: assert property (
      !ref_locked |=> !master_timebase_clock_ok)
      else $error("Timebase shown locked after reference lost");
   AST_LOCK_GATE: assert property (
      q_ff.st == MFC_IDLE && !q_ff.locked |=> q_ff.st == MFC_IDLE)
      else $error("Burst armed without a locked timebase");
   AST_TRIG_START: assert property (
      q_ff.st == MFC_ARMED && tif.trig_out |=> start_go ##0 burst_active)
      else $error("Aligned trigger did not start the burst");
   AST_FAIL_LOCAL: assert property (
      running && !q_ff.comb_mode && cmp_valid && local_fail
      |=> cond_valid && cond_failed)
      else $error("Local failure not given to the sequencer");
   AST_ARM_ORDER: assert property (
      q_ff.st == MFC_IDLE && combine_enable && !sync_enable
      |=> q_ff.st == MFC_IDLE)
      else $error("Combined burst armed before timing module ready");
   AST_FAIL_COMB: assert property (
      running && q_ff.comb_mode && bp_valid && bp_fail_in
      |=> cond_failed)
      else $error("Combined failure did not set failed operand");
   AST_OWN_SITES: assert property (
      running && cmp_valid && !local_fail && bp_valid && bp_fail_in
      |=> $stable(site_pass_fail))
      else $error("Foreign failure leaked into site pass/fail");
   AST_MATCH_COMB: assert property (
      running && q_ff.comb_mode && bp_valid && !bp_match_in
      |=> !cond_matched)
      else $error("Combined matched true while a site missed");
   AST_NO_LOCAL: assert property (
      running && q_ff.comb_mode && !bp_valid |=> !cond_valid)
      else $error("Local branch decision in combined mode");
   AST_MATCH_LOCAL: assert property (
      running && !q_ff.comb_mode && cmp_valid && local_match
      |=> cond_valid && cond_matched)
      else $error("Local match not given to the sequencer");
   AST_COMB_LAT: assert property (
      running && q_ff.comb_mode && bp_valid |=> cond_valid)
      else $error("Combined result not delivered in one cycle");

   COV_LOCAL_FAIL: cover property (cond_valid && cond_failed &&
                                   !q_ff.comb_mode);
   COV_COMB_MATCH: cover property (cond_valid && cond_matched &&
                                   q_ff.comb_mode);
   COV_START: cover property (start_go);
endmodule

/* File: verification/mfc_tmod_model.sv */
/*
 Behavioural timing module: ORs this instrument's fail share and ANDs
 its match share with those of one other instrument, and returns both
 after a fixed latency.
 Assumes shares are valid one cycle after cmp_valid, on sys_clk.
*/
`timescale 1ns/10ps
module mfc_tmod_model #(
   parameter int LAT = 3
) (
   input  wire logic sys_clk,      // System clock
   input  wire logic rst,          // Sync reset, high
   input  wire logic cmp_valid,    // Compare strobe
   input  wire logic bp_fail_out,  // Our fail share
   input  wire logic bp_match_out, // Our match share
   input  wire logic oth_fail,     // Other instrument fail
   input  wire logic oth_match,    // Other instrument match
   output logic      bp_valid,     // Combined ready
   output logic      bp_fail_in,   // Combined fail
   output logic      bp_match_in   // Combined match
);
   logic           vld_d = 1'b0;
   logic [LAT-1:0] v_sr  = '0;
   logic [LAT-1:0] f_sr  = '0;
   logic [LAT-1:0] m_sr  = '0;
   logic           lf    = 1'b0;
   logic           lm    = 1'b0;

   always @(posedge sys_clk) begin
      if (rst) begin
         vld_d <= 1'b0;
         v_sr  <= '0;
      end else begin
         vld_d <= cmp_valid;
         v_sr  <= {v_sr[LAT-2:0], vld_d};
      end
      f_sr <= {f_sr[LAT-2:0], bp_fail_out | oth_fail};
      m_sr <= {m_sr[LAT-2:0], bp_match_out & oth_match};
      if (bp_valid) begin
         lf <= bp_fail_in;
         lm <= bp_match_in;
      end
   end

   // Released result lines show the inverse of the last value
   assign bp_valid    = v_sr[LAT-1];
   assign bp_fail_in  = bp_valid ? f_sr[LAT-1] : ~lf;
   assign bp_match_in = bp_valid ? m_sr[LAT-1] : ~lm;
endmodule

/* File: verification/match_fail_combination_tb_top.sv */
/*
 Self-checking bench for the match/fail combination core: lock
 qualification, trigger latency, local and combined decisions.
 Assumes the behavioural timing module model beside the core.
*/
`timescale 1ns/10ps
module match_fail_combination_tb_top
   import mfc_pkg::*;
;
   logic                      sys_clk, rst, ref_locked, sw_start;
   logic                      sync_enable, combine_enable;
   logic                      burst_arm, burst_done, cmp_valid;
   logic                      oth_fail, oth_match, bp_valid;
   logic                      bp_fail_in, bp_match_in, bp_fail_out;
   logic                      bp_match_out, start_go, burst_active;
   logic                      cond_valid, cond_failed, cond_matched;
   logic                      master_timebase_clock_ok, lf, lm;
   logic [MFC_DLY_W-1:0]      abs_delay;
   logic [MFC_TRIG_LINES-1:0] trig_bus;
   logic [MFC_TSEL_W-1:0]     trig_sel;
   logic [MFC_SITES-1:0]      site_enable, site_fail, site_match;
   logic [MFC_SITES-1:0]      site_in_match, site_pass_fail, sticky;
   logic [31:0]               seed = 32'haa61_bcf4;
   int                        fails = 0;
   int                        comparisons = 0;

   mfc_core DUT (.sys_clk, .rst, .ref_locked, .master_timebase_clock_ok,
      .sync_enable, .combine_enable, .abs_delay, .trig_bus, .trig_sel,
      .sw_start, .burst_arm, .burst_done, .site_enable, .site_fail,
      .site_match, .site_in_match, .cmp_valid, .bp_valid, .bp_fail_in,
      .bp_match_in, .bp_fail_out, .bp_match_out, .start_go,
      .burst_active, .cond_valid, .cond_failed, .cond_matched,
      .site_pass_fail);

   mfc_tmod_model #(.LAT(3)) TM (.sys_clk, .rst, .cmp_valid,
      .bp_fail_out, .bp_match_out, .oth_fail, .oth_match, .bp_valid,
      .bp_fail_in, .bp_match_in);

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Xorshift source and expected results
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic efail(input logic [7:0] en, input logic [7:0] f);
      return |(en & f);
   endfunction
   function automatic logic ematch(input logic [7:0] en,
                                   input logic [7:0] p, input logic [7:0] m);
      return &(~(en & p) | m);
   endfunction

   task automatic step();
      @(posedge sys_clk);
   endtask
   task automatic look();
      @(negedge sys_clk);
   endtask
   task automatic chk_b(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk_v(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic timeout(input string nm);
      fails++;
      $display("BAD %s exp done got timeout", nm);
      results();
   endtask

   // Random sites with corners: none enabled, all failing
   task automatic sites(input int i, input logic v,
                        output logic f, output logic m);
      logic [31:0] a, b;
      logic [7:0]  en, fl, mt;
      a = rnd();
      b = rnd();
      en = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : a[7:0] | a[15:8];
      fl = (i == 1) ? 8'hff : a[23:16] & b[7:0];
      mt = ~(b[15:8] & b[23:16]);
      site_enable <= en;
      site_fail <= fl;
      site_match <= mt;
      site_in_match <= b[31:24];
      f = efail(en, fl);
      m = ematch(en, b[31:24], mt);
      if (v) sticky = sticky | (en & fl);
   endtask

   task automatic burst(input int d, input logic sw, input logic go_exp);
      int          n;
      logic [31:0] r;
      r = rnd();
      step();
      abs_delay <= d[3:0];
      trig_sel <= r[2:0];
      burst_arm <= 1'b1;
      trig_bus <= r[15:8] & ~(8'h01 << r[2:0]);
      step();
      burst_arm <= 1'b0;
      sticky = '0;
      step();
      if (sw) sw_start <= 1'b1;
      else trig_bus[r[2:0]] <= 1'b1;
      n = 0;
      do begin
         step();
         sw_start <= 1'b0;
         look();
         n++;
      end while (!start_go && n < 40);
      chk_b("start_go", go_exp, start_go);
      if (go_exp) begin
         chk_b("start_lat", 1'b1, n == d + 2);
         chk_b("burst_active", 1'b1, burst_active);
         chk_v("pass_fail_arm", 8'h00, site_pass_fail);
         step();
         look();
         chk_b("start_pulse", 1'b0, start_go);
      end
   endtask

   task automatic end_burst();
      step();
      burst_done <= 1'b1;
      step();
      burst_done <= 1'b0;
      trig_bus <= '0;
      step();
      step();
      look();
      chk_b("burst_end", 1'b0, burst_active);
   endtask

   // Local decisions, random gaps and back-to-back compares
   task automatic local_run(input int cnt);
      logic        v, f, m, pv, pf, pm;
      logic [7:0]  ps;
      logic [31:0] r;
      pv = 1'b0;
      pf = 1'b0;
      pm = 1'b0;
      ps = sticky;
      for (int i = 0; i <= cnt; i++) begin
         step();
         r = rnd();
         v = (i < cnt) && (r[0] | r[1]);
         cmp_valid <= v;
         sites(i, v, f, m);
         look();
         chk_b("cond_valid", pv, cond_valid);
         chk_b("fail_share", pv & pf, bp_fail_out);
         chk_b("match_share", !pv | pm, bp_match_out);
         chk_v("pass_fail", ps, site_pass_fail);
         chk_b("cond_failed", pv ? pf : lf, cond_failed);
         chk_b("cond_matched", pv ? pm : lm, cond_matched);
         if (pv) begin
            lf = pf;
            lm = pm;
         end
         pv = v;
         pf = f;
         pm = m;
         ps = sticky;
      end
   endtask

   // Combined decisions through the timing module
   task automatic comb_run(input int cnt);
      logic        f, m, ef, em;
      logic [31:0] r;
      int          n;
      for (int i = 0; i < cnt; i++) begin
         step();
         cmp_valid <= 1'b1;
         sites(i, 1'b1, f, m);
         r = rnd();
         oth_fail <= r[0] & r[1];
         oth_match <= r[2] | r[3];
         step();
         cmp_valid <= 1'b0;
         look();
         chk_b("no_local", 1'b0, cond_valid);
         chk_b("fail_share", f, bp_fail_out);
         n = 0;
         do begin
            step();
            look();
            n++;
         end while (!cond_valid && n < 20);
         if (!cond_valid) timeout("combined");
         chk_b("comb_lat", 1'b1, n == 4);
         ef = f | (r[0] & r[1]);
         em = m & (r[2] | r[3]);
         chk_b("comb_failed", ef, cond_failed);
         chk_b("comb_matched", em, cond_matched);
         chk_v("own_fails", sticky, site_pass_fail);
         lf = ef;
         lm = em;
      end
   endtask

   // Per-site decisions: one burst per site, one site enabled
   task automatic site_loop(input int s);
      logic [31:0] r;
      r = rnd();
      burst(s, 1'b1, 1'b1);
      step();
      cmp_valid <= 1'b1;
      site_enable <= 8'h01 << s;
      site_fail <= r[7:0];
      site_match <= r[15:8];
      site_in_match <= r[23:16];
      step();
      cmp_valid <= 1'b0;
      look();
      chk_b("site_valid", 1'b1, cond_valid);
      chk_b("site_failed", r[s], cond_failed);
      chk_b("site_matched", ~r[16 + s] | r[8 + s], cond_matched);
      chk_v("site_own", (8'h01 << s) & r[7:0], site_pass_fail);
      end_burst();
   endtask

   // Main sequence
   initial begin
      int n;
      {rst, ref_locked, sync_enable, combine_enable} = 4'h8;
      {sw_start, burst_arm, burst_done, cmp_valid} = 4'h0;
      {oth_fail, oth_match, lf, lm} = 4'h0;
      {abs_delay, trig_bus, trig_sel} = '0;
      {site_enable, site_fail, site_match, site_in_match} = '0;
      sticky = '0;
      repeat (6) step();
      rst <= 1'b0;
      look();
      chk_b("rst_match_share", 1'b1, bp_match_out);
      burst(0, 1'b0, 1'b0);
      $display("test lock_refuse done");
      step();
      ref_locked <= 1'b1;
      n = 0;
      do begin
         step();
         look();
         n++;
      end while (!master_timebase_clock_ok && n < 400);
      if (!master_timebase_clock_ok) timeout("lock");
      chk_b("lock_time", 1'b1, n == MFC_LOCK_CYC);
      $display("test lock done");
      for (int k = 0; k < 3; k++) begin
         burst(k * 7 + k / 2, 1'b0, 1'b1);
         local_run(30);
         end_burst();
      end
      $display("test local done");
      for (int s = 0; s < 8; s += 3) begin
         site_loop(s);
      end
      $display("test per_site done");
      step();
      combine_enable <= 1'b1;
      burst(2, 1'b1, 1'b0);
      step();
      sync_enable <= 1'b1;
      burst(5, 1'b1, 1'b1);
      comb_run(8);
      end_burst();
      $display("test combined done");
      results();
   end
endmodule
